// file: hw/gpc_regs.svh
// Register offsets, field positions, reset values and timing counts of the pin group controller.
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH
`define GPC_OFS_DIR        8'h00
`define GPC_OFS_DIR_CLEAR  8'h04
`define GPC_OFS_DIR_SET    8'h08
`define GPC_OFS_DIR_TOGGLE 8'h0c
`define GPC_OFS_OUT        8'h10
`define GPC_OFS_OUT_CLEAR  8'h14
`define GPC_OFS_OUT_SET    8'h18
`define GPC_OFS_OUT_TOGGLE 8'h1c
`define GPC_OFS_IN         8'h20
`define GPC_OFS_CTRL       8'h24
`define GPC_OFS_INEN       8'h28
`define GPC_OFS_PULLEN     8'h2c
`define GPC_OFS_PMUXEN     8'h30
`define GPC_OFS_ANAEN      8'h34
`define GPC_OFS_HALT_CTRL  8'h38
`define GPC_RST_WORD       32'h0000_0000
`define GPC_DBG_HALT_BIT   0
`define GPC_SYNC_CYCLES    2
`endif

// file: hw/gpc_pkg.sv
// Types shared by the pin group controller.
package gpc_pkg;
  typedef enum logic [1:0] {GPC_SZ_BYTE, GPC_SZ_HALF, GPC_SZ_WORD} gpc_size_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    gpc_size_t   size;
    logic [31:0] wdata;
  } gpc_req_t;
  typedef enum logic [1:0] {GPC_OP_WRITE, GPC_OP_CLR, GPC_OP_SET, GPC_OP_TGL} gpc_op_t;
endpackage : gpc_pkg

// file: hw/gpc_pin_group.sv
// Pin group controller with a local port, a delayed peripheral bus port and pad control.
//
// Behaviour
// - One group of up to 32 pins, each pin controlled singly or together.
// - Set, clear, toggle writes of 8, 16 or 32 bits change only chosen pins.
// - During reset all pins are inputs with input, output and pull disabled.
// - Logic keeps running in sleep whenever its clock runs.
// - Local port wins on collision; bus access waits one cycle, an on-demand read two.
// - Local port answers every access in one cycle, sizes 8, 16, 32.
// - Local port reads, writes, sets, clears, toggles direction and level; input read only.
// - Peripheral mux enabled gives the peripheral pad output and pad level.
// - Analog selection disables all digital features of the pad.
// - Debug halt freezes the logic only when the halt control bit is set.
// - Access guard blocks bus writes, never debugger writes.
// - Events go to event routing; no interrupt and no DMA request.
// - Direction one drives pin to its level bit; zero makes it input.
// - Set, clear, toggle strobes with ones change level and direction bits.
// - On-demand sampling delays bus input read two cycles; continuous mode on byte 0 removes it.
// - Pull on input selected by level bit; output driver disables pull.
//
// Our own choices: the placing of the registers and strobed register access.
`include "gpc_regs.svh"
module gpc_pin_group
  import gpc_pkg::*;
#(
  parameter int NPINS = 32
) (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire gpc_req_t          lp_req_i,
  output logic [31:0]            lp_rdata_o,
  input  wire gpc_req_t          bus_req_i,
  input  wire logic              bus_debugger_i,
  input  wire logic              guard_protect_i,
  output logic [31:0]            bus_rdata_o,
  output logic                   bus_ready_o,
  input  wire logic              cpu_halted_i,
  input  wire logic [NPINS-1:0]  pad_in_i,
  output logic [NPINS-1:0]       pad_out_o,
  output logic [NPINS-1:0]       pad_oe_o,
  output logic [NPINS-1:0]       pad_ie_o,
  output logic [NPINS-1:0]       pad_pull_en_o,
  output logic [NPINS-1:0]       pad_pull_up_o,
  input  wire logic [NPINS-1:0]  periph_out_i,
  input  wire logic [NPINS-1:0]  periph_oe_i,
  output logic [NPINS-1:0]       periph_in_o,
  output logic [NPINS-1:0]       event_in_o
);
  localparam int NB = (NPINS + 7) / 8;

  typedef struct packed {
    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] lvl;
    logic [NPINS-1:0] inen;
    logic [NPINS-1:0] pullen;
    logic [NPINS-1:0] pmuxen;
    logic [NPINS-1:0] anaen;
    logic [NB-1:0]    smp;
    logic             dbg_halt;
    logic [NPINS-1:0] sync1;
    logic [NPINS-1:0] sync2;
    logic [1:0]       ondemand_cnt;
    logic             bus_pend;
    gpc_req_t         bus_held;
    logic [31:0]      lp_rdata;
    logic [31:0]      bus_rdata;
    logic             bus_ready;
  } gpc_state_t;

  gpc_state_t s_q;
  gpc_state_t s_d;

  // Byte lanes touched by a sized access; a sub-word access lands on its lane.
  function automatic logic [31:0] lane_mask(input gpc_size_t sz, input logic [1:0] a);
    logic [31:0] m;
    m = 32'h0000_0000;
    unique case (sz)
      GPC_SZ_BYTE: m = 32'h0000_00ff << {a, 3'h0};
      GPC_SZ_HALF: m = 32'h0000_ffff << {a[1], 4'h0};
      GPC_SZ_WORD: m = 32'hffff_ffff;
      default:     m = 32'h0000_0000;
    endcase
    return m;
  endfunction : lane_mask

  // Offset bits 3:2 pick plain write, clear, set or toggle within each set of four.
  function automatic logic [31:0] apply_op(input logic [31:0] cur, input logic [31:0] v,
                                           input logic [31:0] m, input logic [1:0] op);
    logic [31:0] r;
    r = cur;
    unique case (op)
      2'h0: r = (cur & ~m) | (v & m);
      2'h1: r = cur & ~(v & m);
      2'h2: r = cur | (v & m);
      2'h3: r = cur ^ (v & m);
    endcase
    return r;
  endfunction : apply_op

  function automatic logic [31:0] ext(input logic [NPINS-1:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[NPINS-1:0] = v;
    return r;
  endfunction : ext

  logic [NPINS-1:0] in_val;
  logic [NPINS-1:0] smp_mask;
  logic             frozen;

  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      smp_mask[i] = s_q.smp[i/8];
    end
    in_val = s_q.sync2 & s_q.inen & ~s_q.anaen;
  end

  // A CPU halt freezes the logic only while the halt control bit is set.
  assign frozen = cpu_halted_i & s_q.dbg_halt;

  always_comb
  begin
    gpc_req_t    b;
    logic [31:0] m;
    logic [31:0] tmp;
    logic        is_dbg;
    logic        b_go;
    logic        od_start;
    s_d = s_q;
    b = s_q.bus_pend ? s_q.bus_held : bus_req_i;
    m = 32'h0000_0000;
    tmp = 32'h0000_0000;
    is_dbg = bus_debugger_i;
    b_go = 1'b0;
    // Starting an on-demand read clocks the synchroniser at once, so both shifts
    // are done when the held read is answered and no stale level is returned.
    od_start = !frozen && b.rd && !s_q.bus_pend && (b.addr == `GPC_OFS_IN) && !smp_mask[0]
               && (s_q.ondemand_cnt == 2'h0);
    s_d.bus_ready = 1'b0;
    s_d.bus_rdata = 32'h0000_0000;
    s_d.lp_rdata = 32'h0000_0000;
    // Synchronisers run on every edge for bytes in continuous mode, else on demand.
    for (int i = 0; i < NPINS; i++)
    begin
      if (smp_mask[i] || s_q.ondemand_cnt != 2'h0 || od_start)
      begin
        s_d.sync1[i] = pad_in_i[i];
        s_d.sync2[i] = s_q.sync1[i];
      end
    end
    if (!frozen)
    begin
      // Local port first, answered in the same cycle budget with no wait.
      if (lp_req_i.wr)
      begin
        m = lane_mask(lp_req_i.size, lp_req_i.addr[1:0]);
        unique case ({lp_req_i.addr[7:2], 2'h0})
          `GPC_OFS_DIR, `GPC_OFS_DIR_CLEAR, `GPC_OFS_DIR_SET, `GPC_OFS_DIR_TOGGLE:
          begin
            tmp = apply_op(ext(s_q.dir), lp_req_i.wdata, m, lp_req_i.addr[3:2]);
            s_d.dir = tmp[NPINS-1:0];
          end
          `GPC_OFS_OUT, `GPC_OFS_OUT_CLEAR, `GPC_OFS_OUT_SET, `GPC_OFS_OUT_TOGGLE:
          begin
            tmp = apply_op(ext(s_q.lvl), lp_req_i.wdata, m, lp_req_i.addr[3:2]);
            s_d.lvl = tmp[NPINS-1:0];
          end
          default:;
        endcase
      end
      if (lp_req_i.rd)
      begin
        unique case ({lp_req_i.addr[7:2], 2'h0})
          `GPC_OFS_DIR:  s_d.lp_rdata = ext(s_q.dir);
          `GPC_OFS_OUT:  s_d.lp_rdata = ext(s_q.lvl);
          `GPC_OFS_IN:   s_d.lp_rdata = ext(in_val);
          default:       s_d.lp_rdata = 32'h0000_0000;
        endcase
      end
      // A colliding bus access is held and served in the next cycle; an on-demand read after its two shifts.
      if ((b.wr || b.rd) && (lp_req_i.wr || lp_req_i.rd) && !s_q.bus_pend)
      begin
        s_d.bus_pend = 1'b1;
        s_d.bus_held = bus_req_i;
        // A collided on-demand read still waits for both synchroniser shifts.
        if (od_start)
        begin
          s_d.ondemand_cnt = 2'(`GPC_SYNC_CYCLES);
        end
      end
      else if (od_start)
      begin
        s_d.bus_pend = 1'b1;
        s_d.bus_held = b;
        s_d.ondemand_cnt = 2'(`GPC_SYNC_CYCLES);
      end
      else if (s_q.ondemand_cnt > 2'h1)
      begin
        s_d.ondemand_cnt = s_q.ondemand_cnt - 2'h1;
      end
      else
      begin
        b_go = b.wr || b.rd;
        s_d.bus_pend = 1'b0;
        s_d.ondemand_cnt = 2'h0;
      end
    end
    if (b_go)
    begin
      s_d.bus_ready = 1'b1;
      m = lane_mask(b.size, b.addr[1:0]);
      // Guarded writes are still answered, so the master is never left waiting.
      if (b.wr && (!guard_protect_i || is_dbg))
      begin
        // Bus write lands on top of any local write in the same cycle.
        unique case ({b.addr[7:2], 2'h0})
          `GPC_OFS_DIR, `GPC_OFS_DIR_CLEAR, `GPC_OFS_DIR_SET, `GPC_OFS_DIR_TOGGLE:
          begin
            tmp = apply_op(ext(s_d.dir), b.wdata, m, b.addr[3:2]);
            s_d.dir = tmp[NPINS-1:0];
          end
          `GPC_OFS_OUT, `GPC_OFS_OUT_CLEAR, `GPC_OFS_OUT_SET, `GPC_OFS_OUT_TOGGLE:
          begin
            tmp = apply_op(ext(s_d.lvl), b.wdata, m, b.addr[3:2]);
            s_d.lvl = tmp[NPINS-1:0];
          end
          `GPC_OFS_CTRL:   s_d.smp = b.wdata[NB-1:0];
          `GPC_OFS_INEN:   s_d.inen = b.wdata[NPINS-1:0];
          `GPC_OFS_PULLEN: s_d.pullen = b.wdata[NPINS-1:0];
          `GPC_OFS_PMUXEN: s_d.pmuxen = b.wdata[NPINS-1:0];
          `GPC_OFS_ANAEN:  s_d.anaen = b.wdata[NPINS-1:0];
          `GPC_OFS_HALT_CTRL: s_d.dbg_halt = b.wdata[`GPC_DBG_HALT_BIT];
          default:;
        endcase
      end
      if (b.rd)
      begin
        unique case ({b.addr[7:2], 2'h0})
          `GPC_OFS_DIR:     s_d.bus_rdata = ext(s_q.dir);
          `GPC_OFS_OUT:     s_d.bus_rdata = ext(s_q.lvl);
          `GPC_OFS_IN:      s_d.bus_rdata = ext(in_val);
          `GPC_OFS_CTRL:    s_d.bus_rdata[NB-1:0] = s_q.smp;
          `GPC_OFS_INEN:    s_d.bus_rdata = ext(s_q.inen);
          `GPC_OFS_PULLEN:  s_d.bus_rdata = ext(s_q.pullen);
          `GPC_OFS_PMUXEN:  s_d.bus_rdata = ext(s_q.pmuxen);
          `GPC_OFS_ANAEN:   s_d.bus_rdata = ext(s_q.anaen);
          `GPC_OFS_HALT_CTRL: s_d.bus_rdata[`GPC_DBG_HALT_BIT] = s_q.dbg_halt;
          default:          s_d.bus_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Pad muxing: analog beats peripheral, peripheral beats the port.
  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      if (s_q.anaen[i])
      begin
        pad_oe_o[i] = 1'b0;
        pad_out_o[i] = 1'b0;
      end
      else if (s_q.pmuxen[i])
      begin
        pad_oe_o[i] = periph_oe_i[i];
        pad_out_o[i] = periph_out_i[i];
      end
      else
      begin
        pad_oe_o[i] = s_q.dir[i];
        pad_out_o[i] = s_q.lvl[i];
      end
      pad_ie_o[i] = ~s_q.anaen[i] & (s_q.inen[i] | s_q.pmuxen[i]);
      pad_pull_en_o[i] = ~s_q.anaen[i] & s_q.pullen[i] & ~pad_oe_o[i];
      // The pull direction follows the level bit even while a peripheral owns the pad.
      pad_pull_up_o[i] = s_q.lvl[i];
      periph_in_o[i] = s_q.pmuxen[i] & ~s_q.anaen[i] & pad_in_i[i];
    end
  end

  // Only the synchronised input levels leave as events; nothing else is raised.
  assign event_in_o = in_val;
  // Read data and ready leave straight from flip-flops and stand for one cycle.
  assign lp_rdata_o = s_q.lp_rdata;
  assign bus_rdata_o = s_q.bus_rdata;
  assign bus_ready_o = s_q.bus_ready;
endmodule : gpc_pin_group

// file: testbench/gpc_monitor.sv
// Concurrent checks on the ports of the pin group controller.
module gpc_monitor
  import gpc_pkg::*;
#(
  parameter int NPINS = 32
) (
  input wire logic             clock_i,
  input wire logic             rst_n_i,
  input wire gpc_req_t         lp_req_i,
  input wire logic [31:0]      lp_rdata_o,
  input wire gpc_req_t         bus_req_i,
  input wire logic             bus_ready_o,
  input wire logic             cpu_halted_i,
  input wire logic [NPINS-1:0] pad_out_o,
  input wire logic [NPINS-1:0] pad_oe_o,
  input wire logic [NPINS-1:0] pad_ie_o,
  input wire logic [NPINS-1:0] pad_pull_en_o,
  input wire logic [NPINS-1:0] pad_pull_up_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic bus_go = bus_req_i.wr | bus_req_i.rd;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  reset_quiet_a: assert property (
    disable iff (1'b0) !rst_n_i |-> (pad_oe_o | pad_ie_o | pad_pull_en_o) == '0)
    else $error("Pad active in reset");
  rdata_idle_a: assert property (!lp_req_i.rd |=> lp_rdata_o == '0)
    else $error("Local data without read");
  lone_ready_a: assert property (
    bus_req_i.wr && !lp_req_i.wr && !lp_req_i.rd && !cpu_halted_i |=> bus_ready_o)
    else $error("Lone bus write not done in one cycle");
  collide_wait_a: assert property (
    bus_req_i.wr && (lp_req_i.wr || lp_req_i.rd) && !cpu_halted_i |=> !bus_ready_o ##1 bus_ready_o)
    else $error("Collided bus write not one cycle late");
  ready_cause_a: assert property (
    $rose(bus_ready_o) |-> $past(bus_go) || $past(bus_go, 2) || $past(bus_go, 3))
    else $error("Bus ready without request");
  oe_cause_a: assert property ($changed(pad_oe_o) |-> $past(lp_req_i.wr) || bus_ready_o)
    else $error("Pad drive changed without write");
  no_pull_a: assert property ((pad_oe_o & pad_pull_en_o) == '0)
    else $error("Pull on driven pad");
  pull_dir_a: assert property (((pad_pull_up_o ^ pad_out_o) & pad_pull_en_o) == '0)
    else $error("Pull direction differs from level bit");
endmodule : gpc_monitor

bind gpc_pin_group gpc_monitor #(.NPINS(NPINS)) i_gpc_monitor (.clock_i, .rst_n_i, .lp_req_i,
  .lp_rdata_o, .bus_req_i, .bus_ready_o, .cpu_halted_i, .pad_out_o, .pad_oe_o, .pad_ie_o,
  .pad_pull_en_o, .pad_pull_up_o);

// file: testbench/gpc_pad_model.sv
// Pad and peripheral model facing the pin group controller.
module gpc_pad_model (
  input  wire logic        clock_i,
  input  wire logic [31:0] out_i,
  input  wire logic [31:0] oe_i,
  input  wire logic [31:0] pull_en_i,
  input  wire logic [31:0] pull_up_i,
  output logic [31:0]      level_o,
  output logic [31:0]      drive_o,
  output logic [31:0]      drive_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] noise_q = '0;
  // A floating pad toggles every cycle, so a lost pull or driver cannot pass by luck.
  always @(posedge clock_i) noise_q <= ~noise_q;
  assign level_o = (oe_i & out_i) | (~oe_i & pull_en_i & pull_up_i) | (~oe_i & ~pull_en_i & noise_q);
  assign drive_o = 32'h0000_0002;
  assign drive_en_o = '1;
endmodule : gpc_pad_model

// file: testbench/tb_gpc_pin_group.sv
// Self-checking bench for the pin group controller.
`include "gpc_regs.svh"
module tb_gpc_pin_group
  import gpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b1;
  gpc_req_t lp_q = '0;
  gpc_req_t bus_q = '0;
  logic dbg_q = 1'b0;
  logic guard_q = 1'b0;
  logic halt_q = 1'b0;
  logic ready;
  logic [31:0] lp_rd, bus_rd, pad_in, pad_out, pad_oe, pad_ie, pull_en, pull_up;
  logic [31:0] p_out, p_oe, periph_in, event_in, q;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 clock_i = ~clock_i;
  gpc_pin_group #(.NPINS(32)) i_gpc_pin_group (.clock_i, .rst_n_i, .lp_req_i(lp_q),
    .lp_rdata_o(lp_rd), .bus_req_i(bus_q), .bus_debugger_i(dbg_q), .guard_protect_i(guard_q),
    .bus_rdata_o(bus_rd), .bus_ready_o(ready), .cpu_halted_i(halt_q), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_ie_o(pad_ie), .pad_pull_en_o(pull_en),
    .pad_pull_up_o(pull_up), .periph_out_i(p_out), .periph_oe_i(p_oe),
    .periph_in_o(periph_in), .event_in_o(event_in));
  gpc_pad_model i_gpc_pad_model (.clock_i, .out_i(pad_out), .oe_i(pad_oe), .pull_en_i(pull_en),
    .pull_up_i(pull_up), .level_o(pad_in), .drive_o(p_out), .drive_en_o(p_oe));
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic lp(input logic w, input logic [7:0] a, input gpc_size_t s, input logic [31:0] d);
    @(posedge clock_i);
    lp_q <= '{w, !w, a, s, d};
    @(posedge clock_i);
    lp_q <= '0;
    #1;
  endtask : lp
  task automatic lw(input logic [7:0] a, input logic [31:0] d);
    lp(1'b1, a, GPC_SZ_WORD, d);
  endtask : lw
  task automatic lr(input logic [7:0] a, input logic [31:0] e);
    lp(1'b0, a, GPC_SZ_WORD, '0);
    check("local read", lp_rd, e);
  endtask : lr
  // Strobes last one cycle; the wait for ready is bounded so a lost answer cannot hang.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output int n);
    n = 0;
    @(posedge clock_i);
    bus_q <= '{w, !w, a, GPC_SZ_WORD, d};
    @(posedge clock_i);
    bus_q <= '0;
    #1;
    while (ready !== 1'b1 && n < 8)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n == 8)
      check("bus ready", ready, 1'b1);
    q = bus_rd;
  endtask : bus
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    int n;
    bus(1'b1, a, d, n);
  endtask : bw
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    int n;
    // A real falling edge clears the state before the first clock edge is checked.
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    check("reset pads", pad_oe | pad_ie | pull_en, '0);
    rst_n_i <= 1'b1;
    lr(`GPC_OFS_OUT, '0);
    lw(`GPC_OFS_DIR_SET, 32'hffff_0000);
    lw(`GPC_OFS_DIR_CLEAR, 32'h0f00_0000);
    lw(`GPC_OFS_OUT_SET, 32'h0000_00ff);
    lw(`GPC_OFS_OUT_TOGGLE, 32'h0000_0f0f);
    lw(`GPC_OFS_OUT_CLEAR, 32'h0000_00f0);
    lr(`GPC_OFS_DIR, 32'hf0ff_0000);
    lr(`GPC_OFS_OUT, 32'h0000_0f00);
    check("pad drive", pad_oe, 32'hf0ff_0000);
    check("pad level", pad_out, 32'h0000_0f00);
    lp(1'b1, `GPC_OFS_OUT_SET + 8'h01, GPC_SZ_BYTE, 32'h5555_a555);
    lp(1'b1, `GPC_OFS_OUT_TOGGLE + 8'h02, GPC_SZ_HALF, 32'h0001_ffff);
    lr(`GPC_OFS_OUT, 32'h0001_af00);
    $display("Test set clear toggle done");
    lw(`GPC_OFS_OUT_SET, 32'h0000_0081);
    bw(`GPC_OFS_INEN, 32'h0000_00ff);
    bw(`GPC_OFS_PULLEN, 32'h0000_00ff);
    check("pull up", pull_up & pull_en, 32'h0000_0081);
    bus(1'b0, `GPC_OFS_IN, '0, n);
    check("on demand wait", n, 2);
    check("input byte", q & 32'hff, 32'h81);
    bw(`GPC_OFS_CTRL, 32'h1);
    bus(1'b0, `GPC_OFS_IN, '0, n);
    check("continuous wait", n, 0);
    lw(`GPC_OFS_IN, '0);
    lp(1'b0, `GPC_OFS_IN, GPC_SZ_WORD, '0);
    check("local input", lp_rd & 32'hff, 32'h81);
    check("event level", event_in & 32'hff, 32'h81);
    lw(`GPC_OFS_DIR_SET, 32'h1);
    check("pull off", pull_en & 32'hff, 32'hfe);
    lw(`GPC_OFS_DIR_CLEAR, 32'h1);
    $display("Test input done");
    @(posedge clock_i);
    guard_q <= 1'b1;
    bw(`GPC_OFS_DIR_SET, 32'h0000_0100);
    lr(`GPC_OFS_DIR, 32'hf0ff_0000);
    @(posedge clock_i);
    dbg_q <= 1'b1;
    bw(`GPC_OFS_DIR_SET, 32'h0000_0100);
    lr(`GPC_OFS_DIR, 32'hf0ff_0100);
    @(posedge clock_i);
    guard_q <= 1'b0;
    dbg_q <= 1'b0;
    bw(`GPC_OFS_PMUXEN, 32'h2);
    check("mux pin", {pad_oe[1], pad_out[1], periph_in[1]}, 3'b111);
    bw(`GPC_OFS_ANAEN, 32'h4);
    check("analog pin", {pad_ie[2], pull_en[2], pad_oe[2]}, '0);
    bus(1'b0, 8'h3c, '0, n);
    check("unmapped", q, '0);
    $display("Test guard and mux done");
    @(posedge clock_i);
    halt_q <= 1'b1;
    lw(`GPC_OFS_OUT_TOGGLE, 32'h0000_8000);
    bw(`GPC_OFS_HALT_CTRL, 32'h1);
    lw(`GPC_OFS_OUT_TOGGLE, 32'h0000_8000);
    @(posedge clock_i);
    halt_q <= 1'b0;
    lr(`GPC_OFS_OUT, 32'h0001_2f81);
    @(posedge clock_i);
    lp_q <= '{1'b1, 1'b0, `GPC_OFS_OUT_SET, GPC_SZ_WORD, 32'h8};
    bus_q <= '{1'b1, 1'b0, `GPC_OFS_OUT_TOGGLE, GPC_SZ_WORD, 32'h8};
    @(posedge clock_i);
    lp_q <= '0;
    bus_q <= '0;
    #1;
    check("collided ready", ready, 1'b0);
    @(posedge clock_i);
    #1;
    check("late ready", ready, 1'b1);
    lr(`GPC_OFS_OUT, 32'h0001_2f81);
    $display("Test halt and priority done");
    tally_and_finish();
  end
endmodule : tb_gpc_pin_group
